// ===== rf_check_pkg.sv
package rf_check_pkg;
    // system clock and base clock period
    localparam int SYS_PERIOD_NS = 10;
    // short base period keeps a whole poll cycle to about 16 thousand cycles, 15360 of them start-up
    localparam int TCLK_NS = 200;
    localparam int TCLK_CYC = TCLK_NS / SYS_PERIOD_NS;
    // start-up length in base clocks (plain default)
    localparam logic [17:0] STARTUP_TCLK = 18'h00300;
    // sleep value that means permanent sleep
    localparam logic [4:0] SLEEP_FOREVER = 5'h1F;
    // conditioning limits in extended clocks
    localparam logic [7:0] DATA_MIN_XCLK = 8'h0A;
    localparam logic [7:0] DATA_LOW_MAX_XCLK = 8'hC0;
    // bit-check counter width and reset values
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
    // buffer geometry
    localparam int BUF_W = 2;
    localparam int BUF_DEPTH = 16;
    // polling / receive states
    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_STARTUP,
        ST_CHECK,
        ST_RECEIVE
    } poll_state_t;
endpackage : rf_check_pkg

// ===== stream_if.sv
`timescale 1ns/1ns
`default_nettype none
// one valid/ready word channel
interface stream_if #(
    parameter int W = 2
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// ===== word_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
    parameter int W = 2,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // filling and draining sides
    stream_if.snk wr,
    stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];     // flip-flop storage
    logic [AW-1:0] wp_r, wp_nxt;     // write index
    logic [AW-1:0] rp_r, rp_nxt;     // read index
    logic [AW:0] cnt_r, cnt_nxt;     // fill level
    logic push, pop;

    // honest flags straight from the fill level
    assign wr.ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign rd.valid = (cnt_r != '0);
    assign rd.data = mem_r[rp_r];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // next pointers and level
    always_comb begin
        wp_nxt = push ? wp_r + AW'(1) : wp_r;
        rp_nxt = pop ? rp_r + AW'(1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    // pointers and level registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage written per entry, no reset needed
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge clk_sys_i) begin
                if (push && wp_r == AW'(i)) begin
                    mem_r[i] <= wr.data;
                end
            end
        end
    endgenerate
endmodule : word_fifo
`default_nettype wire

// ===== rf_bit_check.sv
`timescale 1ns/1ns
`default_nettype none
module rf_bit_check
    import rf_check_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // demodulator output, asynchronous
    input wire logic dem_out_i,
    // operating-mode settings
    input wire logic [1:0] baud_range_select_i,
    input wire logic [1:0] bit_count_sel_i,
    input wire logic [4:0] sleep_value_i,
    input wire logic sleep_stretch_i,
    input wire logic noise_disable_i,
    // window limits
    input wire logic [4:0] lim_min_i,
    input wire logic [4:0] lim_max_i,
    // command back to polling, one-cycle pulse
    input wire logic poll_cmd_i,
    // outputs toward the host
    output logic data_o,
    output logic data_clk_o,
    output logic activity_indicator_o,
    output logic receiving_o
);
    stream_if #(.W(BUF_W)) fin ();   // conditioner into buffer
    stream_if #(.W(BUF_W)) fout ();  // buffer into output stage

    // pin synchroniser, stage one read only by stage two
    logic dem_s1_r, dem_s2_r;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dem_s1_r <= 1'b1;
            dem_s2_r <= 1'b1;
        end else begin
            dem_s1_r <= dem_out_i;
            dem_s2_r <= dem_s1_r;
        end
    end

    // base clock and extended clock prescalers
    logic [7:0] base_r, base_nxt;    // system cycles per base clock
    logic [2:0] xdiv_r, xdiv_nxt;    // base clocks per extended clock
    logic [2:0] xlast;               // factor minus one
    logic base_tick, xtick;
    assign base_tick = (base_r == 8'(TCLK_CYC - 1));
    assign xlast = 3'(4'h8 >> baud_range_select_i) - 3'h1;
    assign xtick = base_tick && (xdiv_r >= xlast);
    always_comb begin
        base_nxt = base_tick ? 8'h00 : base_r + 8'h01;
        xdiv_nxt = xdiv_r;
        if (xtick) begin
            xdiv_nxt = 3'h0;
        end else if (base_tick) begin
            xdiv_nxt = xdiv_r + 3'h1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            base_r <= 8'h00;
            xdiv_r <= 3'h0;
        end else begin
            base_r <= base_nxt;
            xdiv_r <= xdiv_nxt;
        end
    end

    // polling sequencer and bit check
    poll_state_t st_r, st_nxt;
    logic [17:0] tmr_r, tmr_nxt;     // sleep / start-up base clocks
    logic [CNT_W-1:0] cnt_r, cnt_nxt; // window counter value
    logic [4:0] chk_r, chk_nxt;      // passed interval checks
    logic armed_r, armed_nxt;        // first edge seen
    logic prev_r, prev_nxt;          // demod level at last tick
    logic [17:0] sleep_len;
    logic [4:0] chk_target;
    logic edge_seen;
    // sleep = value * stretch * 1024 base clocks
    assign sleep_len = sleep_stretch_i ? {sleep_value_i, 13'h0000}
                                       : {3'h0, sleep_value_i, 10'h000};
    // two checks per bit: 0, 6, 12, 18
    assign chk_target = 5'(bit_count_sel_i) * 5'h06;
    assign edge_seen = xtick && (dem_s2_r != prev_r);

    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        cnt_nxt = cnt_r;
        chk_nxt = chk_r;
        armed_nxt = armed_r;
        prev_nxt = xtick ? dem_s2_r : prev_r;
        unique case (st_r)
            ST_SLEEP: begin
                // permanent sleep holds until value changes
                if (base_tick && sleep_value_i != SLEEP_FOREVER) begin
                    tmr_nxt = tmr_r + 18'h00001;
                    if (tmr_r + 18'h00001 >= sleep_len) begin
                        st_nxt = ST_STARTUP;
                        tmr_nxt = 18'h00000;
                    end
                end
            end
            ST_STARTUP: begin
                // demod undefined here, nothing is judged
                if (base_tick) begin
                    tmr_nxt = tmr_r + 18'h00001;
                end
                if (base_tick && tmr_r + 18'h00001 >= STARTUP_TCLK) begin
                    tmr_nxt = 18'h00000;
                    cnt_nxt = CNT_RST;
                    chk_nxt = 5'h00;
                    armed_nxt = 1'b0;
                    // zero bits means straight to receive
                    st_nxt = (chk_target == 5'h00) ? ST_RECEIVE
                                                   : ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (xtick) begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (edge_seen && armed_r) begin
                        cnt_nxt = CNT_RST;
                        if (cnt_r < {1'b0, lim_min_i}) begin
                            st_nxt = ST_SLEEP;
                        end else begin
                            chk_nxt = chk_r + 5'h01;
                            if (chk_r + 5'h01 >= chk_target) begin
                                st_nxt = ST_RECEIVE;
                            end
                        end
                    end else if (edge_seen) begin
                        // first edge only starts the timing
                        armed_nxt = 1'b1;
                        cnt_nxt = CNT_RST;
                    end else if (cnt_r + 6'h01 >= {1'b0, lim_max_i}) begin
                        st_nxt = ST_SLEEP;
                    end
                end
            end
            ST_RECEIVE: begin
                // stays here whatever the demod does
                if (poll_cmd_i) begin
                    st_nxt = ST_SLEEP;
                    tmr_nxt = 18'h00000;
                end
            end
        endcase
        if (st_r == ST_CHECK && st_nxt == ST_SLEEP) begin
            tmr_nxt = 18'h00000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_r <= ST_SLEEP;
            tmr_r <= 18'h00000;
            cnt_r <= CNT_RST;
            chk_r <= 5'h00;
            armed_r <= 1'b0;
            prev_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
            chk_r <= chk_nxt;
            armed_r <= armed_nxt;
            prev_r <= prev_nxt;
        end
    end

    // data conditioner, advances on extended ticks while buffer has room
    logic cond_r, cond_nxt;          // conditioned level
    logic [7:0] spc_r, spc_nxt;      // ticks since last output edge
    logic [7:0] low_r, low_nxt;      // ticks spent low
    logic hold_r, hold_nxt;          // low limit hit, forced high
    logic quiet_r, quiet_nxt;        // transmission over, stay high
    logic start_r, start_nxt;        // start bit detected
    logic clk_bit;
    logic want;
    logic step;
    // back-pressure: a full buffer stalls the conditioner
    assign step = xtick && fin.ready && st_r == ST_RECEIVE;
    assign want = (hold_r || quiet_r) ? 1'b1 : dem_s2_r;

    always_comb begin
        cond_nxt = cond_r;
        spc_nxt = spc_r;
        low_nxt = low_r;
        hold_nxt = hold_r;
        quiet_nxt = quiet_r;
        start_nxt = start_r;
        clk_bit = 1'b0;
        if (st_r != ST_RECEIVE) begin
            // idle high, counters reloaded for next reception
            cond_nxt = 1'b1;
            spc_nxt = DATA_MIN_XCLK;
            low_nxt = 8'h00;
            hold_nxt = 1'b0;
            quiet_nxt = 1'b0;
            start_nxt = 1'b0;
        end else if (step) begin
            if (spc_r != 8'hFF) begin
                spc_nxt = spc_r + 8'h01;
            end
            if (hold_r && dem_s2_r) begin
                hold_nxt = 1'b0;
            end
            if (!cond_r && low_r + 8'h01 >= DATA_LOW_MAX_XCLK) begin
                // low held too long: release the line
                cond_nxt = 1'b1;
                spc_nxt = 8'h00;
                low_nxt = 8'h00;
                hold_nxt = 1'b1;
                quiet_nxt = noise_disable_i;
            end else if (want != cond_r && spc_r >= DATA_MIN_XCLK) begin
                cond_nxt = want;
                spc_nxt = 8'h00;
                low_nxt = 8'h00;
                // the first falling edge is the start bit
                if (!want) begin
                    start_nxt = 1'b1;
                end
                clk_bit = start_r;
            end else if (!cond_r) begin
                low_nxt = low_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cond_r <= 1'b1;
            spc_r <= DATA_MIN_XCLK;
            low_r <= 8'h00;
            hold_r <= 1'b0;
            quiet_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            cond_r <= cond_nxt;
            spc_r <= spc_nxt;
            low_r <= low_nxt;
            hold_r <= hold_nxt;
            quiet_r <= quiet_nxt;
            start_r <= start_nxt;
        end
    end

    // one word per tick: bit clock mark and next level
    assign fin.valid = step;
    assign fin.data = {clk_bit, cond_nxt};

    word_fifo #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .wr(fin),
        .rd(fout)
    );

    // output stage drains one word per tick, so pin edges stay on ticks
    logic data_r, data_nxt;
    logic dclk_r, dclk_nxt;
    logic act_r, act_nxt;
    logic rx_r, rx_nxt;
    assign fout.ready = xtick;
    always_comb begin
        data_nxt = data_r;
        dclk_nxt = dclk_r;
        if (fout.valid && fout.ready) begin
            data_nxt = fout.data[0];
            dclk_nxt = fout.data[1];
        end else if (xtick) begin
            dclk_nxt = 1'b0;
        end
        if (st_r != ST_RECEIVE) begin
            data_nxt = 1'b1;
            dclk_nxt = 1'b0;
        end
        act_nxt = (st_nxt != ST_SLEEP);
        rx_nxt = (st_nxt == ST_RECEIVE);
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            data_r <= 1'b1;
            dclk_r <= 1'b0;
            act_r <= 1'b0;
            rx_r <= 1'b0;
        end else begin
            data_r <= data_nxt;
            dclk_r <= dclk_nxt;
            act_r <= act_nxt;
            rx_r <= rx_nxt;
        end
    end

    assign data_o = data_r;
    assign data_clk_o = dclk_r;
    assign activity_indicator_o = act_r;
    assign receiving_o = rx_r;
endmodule : rf_bit_check
`default_nettype wire

// ===== rf_bit_check_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rf_bit_check_chk
    import rf_check_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // settings
    input wire logic [1:0] baud_range_select_i,
    input wire logic [4:0] sleep_value_i,
    input wire logic poll_cmd_i,
    // watched outputs
    input wire logic data_o,
    input wire logic data_clk_o,
    input wire logic activity_indicator_o,
    input wire logic receiving_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    int xcyc; // system cycles per extended tick
    assign xcyc = TCLK_CYC * (8 >> baud_range_select_i);
    logic data_q_r, data_q_nxt; // data_o one cycle back
    logic rx_q_r, rx_q_nxt; // receiving_o one cycle back
    logic seen_r, seen_nxt; // start bit seen in this receive
    int gap_r, gap_nxt; // cycles since last data edge
    int low_r, low_nxt; // cycles data held low
    // next values; outside receive the gap is parked huge
    always_comb begin
        data_q_nxt = data_o;
        rx_q_nxt = receiving_o;
        gap_nxt = (data_o != data_q_r) ? 1 : gap_r + 1;
        low_nxt = data_o ? 0 : low_r + 1;
        seen_nxt = (seen_r | (data_q_r & ~data_o)) & ~(receiving_o & ~rx_q_r);
        if (!receiving_o) begin
            gap_nxt = 32'h00FF_FFFF;
            low_nxt = 0;
        end
    end
    // registers only
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            data_q_r <= 1'b1;
            rx_q_r <= 1'b0;
            seen_r <= 1'b0;
            gap_r <= 32'h00FF_FFFF;
            low_r <= 0;
        end else begin
            data_q_r <= data_q_nxt;
            rx_q_r <= rx_q_nxt;
            seen_r <= seen_nxt;
            gap_r <= gap_nxt;
            low_r <= low_nxt;
        end
    end
    AST_RECV_HOLDS: assert property (
        receiving_o && !poll_cmd_i |=> receiving_o)
        else $error("receive mode left without command");
    AST_POLL_EXIT: assert property (
        receiving_o && poll_cmd_i |-> ##[1:3] !receiving_o)
        else $error("poll command did not end receive mode");
    AST_RECV_ACTIVE: assert property (
        $rose(receiving_o) |-> activity_indicator_o)
        else $error("receive entered while shown asleep");
    AST_EDGE_SPACING: assert property (
        receiving_o && rx_q_r && data_o != data_q_r
        |-> gap_r >= int'(DATA_MIN_XCLK) * xcyc)
        else $error("data edges too close");
    AST_TICK_MULT: assert property (
        receiving_o && rx_q_r && data_o != data_q_r
        && gap_r < 32'h0010_0000 |-> gap_r % xcyc == 0)
        else $error("data edge off the extended tick grid");
    AST_LOW_LIMIT: assert property (
        low_r <= (int'(DATA_LOW_MAX_XCLK) + 2) * xcyc)
        else $error("data held low too long");
    AST_CLK_START: assert property (
        data_clk_o |-> seen_r || (data_q_r && !data_o))
        else $error("data clock before start bit");
    AST_SLEEP_FOREVER: assert property (
        sleep_value_i == SLEEP_FOREVER
        && $past(sleep_value_i) == SLEEP_FOREVER
        && !activity_indicator_o |=> !activity_indicator_o)
        else $error("woke from permanent sleep");
endmodule : rf_bit_check_chk
bind rf_bit_check rf_bit_check_chk u_chk (
    .clk_sys_i, .reset_i, .baud_range_select_i, .sleep_value_i,
    .poll_cmd_i, .data_o, .data_clk_o, .activity_indicator_o, .receiving_o
);
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // pins seen by the host
    input wire logic clk_sys_i,
    input wire logic data_i,
    input wire logic data_clk_i,
    input wire logic enable_i,
    // edge statistics
    output var int edges_o,
    output var int min_gap_o,
    output var logic early_clk_o,
    output var logic clk_seen_o
);
    int gap; // cycles since last data edge
    logic last; // previous data level
    logic started; // falling edge seen, host woken
    logic fall;
    assign fall = last & ~data_i;
    initial begin
        edges_o = 0;
        min_gap_o = 32'h7FFF_FFFF;
        early_clk_o = 1'b0;
        clk_seen_o = 1'b0;
        gap = 0;
        last = 1'b1;
        started = 1'b0;
    end
    // timestamp every edge, as an interrupt-driven host would
    always @(posedge clk_sys_i) begin
        gap <= gap + 1;
        last <= data_i;
        if (enable_i && data_i !== last) begin
            if (edges_o > 0 && gap < min_gap_o) begin
                min_gap_o <= gap;
            end
            edges_o <= edges_o + 1;
            gap <= 1;
        end
        if (enable_i) begin
            started <= started | fall;
            early_clk_o <= early_clk_o | (data_clk_i & ~started & ~fall);
            clk_seen_o <= clk_seen_o | (data_clk_i & started);
        end
    end
endmodule : host_model
`default_nettype wire

// ===== tb_rf_bit_check.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rf_bit_check import rf_check_pkg::*;;
    localparam int XC = TCLK_CYC; // baud range 3: one base tick
    localparam int SU = int'(STARTUP_TCLK) * TCLK_CYC; // start-up cycles
    logic clk_sys_i, reset_i, dem_out_i, sleep_stretch_i, noise_disable_i;
    logic [1:0] baud_range_select_i, bit_count_sel_i;
    logic [4:0] sleep_value_i, lim_min_i, lim_max_i;
    logic poll_cmd_i, data_o, data_clk_o, activity_indicator_o, receiving_o;
    int err_total, cmp_count, cyc, dem_per, dem_cnt, t0, edges, min_gap;
    logic early_clk, clk_seen;
    rf_bit_check DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .dem_out_i(dem_out_i), .baud_range_select_i(baud_range_select_i),
        .bit_count_sel_i(bit_count_sel_i), .sleep_value_i(sleep_value_i),
        .sleep_stretch_i(sleep_stretch_i), .noise_disable_i(noise_disable_i),
        .lim_min_i(lim_min_i), .lim_max_i(lim_max_i), .poll_cmd_i(poll_cmd_i),
        .data_o(data_o), .data_clk_o(data_clk_o), .receiving_o(receiving_o),
        .activity_indicator_o(activity_indicator_o));
    host_model u_host (.clk_sys_i(clk_sys_i), .data_i(data_o),
        .data_clk_i(data_clk_o), .enable_i(receiving_o), .edges_o(edges),
        .min_gap_o(min_gap), .early_clk_o(early_clk), .clk_seen_o(clk_seen));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // read: wait for activity (rx=0) or receive (rx=1) to reach val
    task automatic wait_out(input bit rx, input logic val, input int lim);
        int n;
        logic lvl;
        n = 0;
        lvl = rx ? receiving_o : activity_indicator_o;
        while (lvl !== val && n < lim) begin
            @(posedge clk_sys_i);
            #1;
            n++;
            lvl = rx ? receiving_o : activity_indicator_o;
        end
        check(lvl, val);
    endtask : wait_out
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cycles
    // demodulator stand-in: toggles every dem_per cycles, stuck low if < 0
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            dem_out_i <= 1'b1;
            dem_cnt <= 0;
        end else if (dem_per < 0) begin
            dem_out_i <= 1'b0;
        end else if (dem_per != 0) begin
            dem_cnt <= (dem_cnt + 1 >= dem_per) ? 0 : dem_cnt + 1;
            if (dem_cnt + 1 >= dem_per) begin
                dem_out_i <= ~dem_out_i;
            end
        end
    end
    // run ceiling: the whole sequence needs about 84k cycles
    localparam int LIMIT = 95000;
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
        if (cyc == LIMIT) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        err_total = 0;
        cmp_count = 0;
        dem_per = 0;
        reset_i = 1'b1;
        poll_cmd_i = 1'b0;
        baud_range_select_i = 2'h3;
        sleep_stretch_i = 1'b0;
        bit_count_sel_i = 2'h3;
        noise_disable_i = 1'b0;
        sleep_value_i = SLEEP_FOREVER;
        lim_min_i = 5'h0A;
        lim_max_i = 5'h14;
        cycles(8);
        reset_i <= 1'b0;
        cycles(3000);
        check(activity_indicator_o, 1'b0);
        $display("test sleep done");
        sleep_value_i <= 5'h00;
        wait_out(0, 1'b1, 5000);
        dem_per <= 5 * XC; // intervals below the lower limit
        wait_out(0, 1'b0, 200000);
        check(receiving_o, 1'b0);
        $display("test short done");
        wait_out(0, 1'b1, 5000);
        t0 = cyc;
        @(posedge clk_sys_i);
        dem_per <= 25 * XC; // intervals beyond the upper limit
        wait_out(0, 1'b0, 200000);
        check(cyc - t0 >= SU && cyc - t0 <= SU + 60 * XC, 1'b1);
        check(receiving_o, 1'b0);
        $display("test long done");
        wait_out(0, 1'b1, 5000);
        t0 = cyc;
        @(posedge clk_sys_i);
        bit_count_sel_i <= 2'h2;
        dem_per <= 14 * XC;
        wait_out(1, 1'b1, 300000);
        t0 = cyc - t0;
        check(t0 >= SU + 168 * XC && t0 <= SU + 200 * XC, 1'b1);
        cycles(280 * XC);
        dem_per <= 3 * XC; // spikes shorter than the minimum spacing
        cycles(60 * XC);
        check(edges > 10, 1'b1);
        check(min_gap >= int'(DATA_MIN_XCLK) * XC, 1'b1);
        check(min_gap % XC, 0);
        check({early_clk, clk_seen}, 2'b01);
        $display("test receive done");
        dem_per <= -1; // transmission ends, demodulator stuck low
        noise_disable_i <= 1'b1;
        // the fall may first wait out a full edge spacing
        cycles((int'(DATA_LOW_MAX_XCLK) + 16) * XC);
        check(data_o, 1'b1);
        t0 = edges;
        cycles(40 * XC);
        check(edges, t0);
        check({data_o, receiving_o}, 2'b11);
        $display("test idle done");
        poll_cmd_i <= 1'b1;
        baud_range_select_i <= 2'h0; // factor 8 for the next check
        @(posedge clk_sys_i);
        poll_cmd_i <= 1'b0;
        cycles(3);
        #1;
        check(receiving_o, 1'b0);
        $display("test poll done");
        // no demod edges: check dies after 20 extended ticks of 8 base
        wait_out(0, 1'b1, 5000);
        t0 = cyc;
        wait_out(0, 1'b0, 30000);
        t0 = cyc - t0;
        check(t0 >= SU + 152 * XC && t0 <= SU + 161 * XC, 1'b1);
        $display("test range done");
        give_verdict();
    end
endmodule : tb_rf_bit_check
`default_nettype wire
